// file: logic/vic_map.vh
// Register map, field positions and vectors of the interrupt controller
`ifndef VIC_MAP_VH
`define VIC_MAP_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define VIC_ADR_EDGE 8'h00
`define VIC_ADR_CTRL0 8'h04
`define VIC_ADR_CTRL1 8'h08
`define VIC_ADR_GRP0 8'h0C
`define VIC_ADR_GRP1 8'h10
`define VIC_ADR_STAT 8'h14
`define VIC_ADR_EVT 8'h18
`define VIC_ADR_MASK 8'h1C
// ----------------------------------------
// Reset values
// ----------------------------------------
`define VIC_RST_BYTE 8'h00
`define VIC_RST_EVT 3'h0
// ----------------------------------------
// Field positions, control 0
// ----------------------------------------
`define VIC_C0_GIE 0
`define VIC_C0_EXTE 1
`define VIC_C0_G0E 2
`define VIC_C0_G1E 3
`define VIC_C0_EXTF 4
`define VIC_C0_G0F 5
`define VIC_C0_G1F 6
// ----------------------------------------
// Field positions, control 1
// ----------------------------------------
`define VIC_C1_T0E 0
`define VIC_C1_T1E 1
`define VIC_C1_CVE 3
`define VIC_C1_T0F 4
`define VIC_C1_T1F 5
`define VIC_C1_CVF 7
// ----------------------------------------
// Group registers: enables 1:0, flags 5:4
// ----------------------------------------
`define VIC_GRP_PE 0
`define VIC_GRP_AE 1
`define VIC_GRP_PF 4
`define VIC_GRP_AF 5
// ----------------------------------------
// Vectors, highest priority first
// ----------------------------------------
`define VIC_VEC_EXT 5'h04
`define VIC_VEC_G0 5'h08
`define VIC_VEC_G1 5'h0C
`define VIC_VEC_T0 5'h10
`define VIC_VEC_T1 5'h14
`define VIC_VEC_CV 5'h1C
// ----------------------------------------
// Edge select codes
// ----------------------------------------
`define VIC_EDGE_OFF 2'h0
`define VIC_EDGE_RISE 2'h1
`define VIC_EDGE_FALL 2'h2
`define VIC_EDGE_BOTH 2'h3
`endif

// file: logic/vic_top.v
// Vectored interrupt controller with Wishbone register access
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
// Notes on behaviour
// - Source event sets its request flag
// - Jump only when own enable is set
// - Global enable low blocks every source
// - Taking interrupt pushes next program counter
// - Then vector address loads program counter
// - Return instruction pops saved program counter
// - Service clears global enable, no nesting
// - Flags keep latching while globally disabled
// - Full stack holds off every request
// - Fixed priority: pin, groups, ticks, converter
// - Timer matches share group vectors
// - Group members not auto-cleared; direct are
// - Any flag becoming set wakes device
// - Periodic register: flags 5:4, enables 1:0
// - Bits 7:6 and 3:2 read zero
// - Edge select: off, rise, fall, both
// - Group flag set when member flag sets
//
// Interfaces in brief
// Register bus: classic single cycle, ack one cycle after request
// Only byte lane 0 carries write data; status reads also use lane 1
// Unmapped addresses read zero and swallow writes
// Core link: a boundary pulse asks for a decision
// Call strobe comes one cycle after a taken boundary
// Pushed address and vector hold until the next call
// Return strobe is echoed one cycle later as pop
// Stack lives in the core; only its full level comes here
//
// Hazards and limits
// Pin edges arrive about three cycles late through the synchroniser
// Hardware set beats every clear, so no event is lost
// Group members ignore their enables when raising the group flag
// Last vector in status is a debug aid only
`include "vic_map.vh"
module vic_top #(
  parameter PC_W = 13 // Program counter width
) (
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  input wire WB_CYC_IN,
  input wire WB_STB_IN,
  input wire WB_WE_IN,
  input wire [7:0] WB_ADR_IN,
  input wire [3:0] WB_SEL_IN,
  input wire [31:0] WB_DAT_IN,
  output wire [31:0] WB_DAT_OUT,
  output wire WB_ACK_OUT,
  input wire EXT_PIN_IN,
  input wire STD_MATCH_P_IN,
  input wire STD_MATCH_A_IN,
  input wire PER_MATCH_P_IN,
  input wire PER_MATCH_A_IN,
  input wire TICK0_IN,
  input wire TICK1_IN,
  input wire CONV_DONE_IN,
  input wire CORE_BOUNDARY_IN,
  input wire [PC_W-1:0] CORE_NEXT_PC_IN,
  input wire CORE_RETURN_IN,
  input wire STACK_FULL_IN,
  output wire CALL_OUT,
  output wire [PC_W-1:0] PUSH_PC_OUT,
  output wire [PC_W-1:0] VECTOR_OUT,
  output wire POP_OUT,
  output wire WAKE_OUT,
  output wire IRQ_OUT
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Flag update: hardware set beats both clear and write
  function upd;
    input q;
    input wr;
    input wd;
    input set;
    input clr;
    begin
      upd = set | (~clr & (wr ? wd : q));
    end
  endfunction

  // Fixed priority, bit 0 highest; one-hot grant
  function [5:0] prio;
    input [5:0] req;
    begin
      prio = req & ~(req - 6'h01) ;
    end
  endfunction

  // Vector of a one-hot grant
  function [4:0] vec_of;
    input [5:0] g;
    begin
      if (g[0]) begin
        vec_of = `VIC_VEC_EXT;
      end else if (g[1]) begin
        vec_of = `VIC_VEC_G0;
      end else if (g[2]) begin
        vec_of = `VIC_VEC_G1;
      end else if (g[3]) begin
        vec_of = `VIC_VEC_T0;
      end else if (g[4]) begin
        vec_of = `VIC_VEC_T1;
      end else begin
        vec_of = `VIC_VEC_CV;
      end
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg ack_q; // Bus acknowledge
  reg [31:0] rdat_q; // Read data
  reg [1:0] edge_q; // Pin edge select
  reg [1:0] edge_rsv_q; // Reserved, stored
  reg gie_q; // Global enable
  reg [2:0] c0_en_q; // Pin, group0, group1 enables
  reg [5:0] dflag_q; // Direct flags, priority order
  reg [2:0] c1_en_q; // Tick0, tick1, converter enables
  reg [1:0] c1_rsv_q; // Reserved, stored
  reg [3:0] mflag_q; // Members: std P,A, per P,A
  reg [3:0] men_q; // Member enables, same order
  reg [2:0] evt_q; // Event status
  reg [2:0] mask_q; // Event mask
  reg call_q; // Call strobe
  reg pop_q; // Pop strobe
  reg wake_q; // Wake strobe
  reg [PC_W-1:0] push_q; // Pushed program counter
  reg [PC_W-1:0] vec_q; // Vector address
  reg [4:0] last_vec_q; // Last serviced vector
  reg pin_s1_q; // Synchroniser stage 1
  reg pin_s2_q; // Synchroniser stage 2
  reg pin_old_q; // Previous synced level

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Request seen while cyc and stb are both high
  wire req = WB_CYC_IN & WB_STB_IN;
  // Write lands on the edge the master sees ack
  wire wr = req & WB_WE_IN & ack_q & WB_SEL_IN[0];
  // All writable registers sit in the low byte lane
  wire [7:0] wd = WB_DAT_IN[7:0];
  wire wr_edge = wr & (WB_ADR_IN == `VIC_ADR_EDGE);
  wire wr_c0 = wr & (WB_ADR_IN == `VIC_ADR_CTRL0);
  wire wr_c1 = wr & (WB_ADR_IN == `VIC_ADR_CTRL1);
  wire wr_g0 = wr & (WB_ADR_IN == `VIC_ADR_GRP0);
  wire wr_g1 = wr & (WB_ADR_IN == `VIC_ADR_GRP1);
  wire wr_evt = wr & (WB_ADR_IN == `VIC_ADR_EVT);
  wire wr_mask = wr & (WB_ADR_IN == `VIC_ADR_MASK);

  // ----------------------------------------
  // Source events
  // ----------------------------------------
  // Pin edges from the synchronised level only
  // Old level resets low, matching an idle low pin
  wire pin_rise = pin_s2_q & ~pin_old_q;
  wire pin_fall = ~pin_s2_q & pin_old_q;
  reg ext_set; // Selected pin edge seen
  always @* begin
    case (edge_q)
      `VIC_EDGE_RISE: ext_set = pin_rise;
      `VIC_EDGE_FALL: ext_set = pin_fall;
      `VIC_EDGE_BOTH: ext_set = pin_rise | pin_fall;
      default: ext_set = 1'b0;
    endcase
  end

  // Member flag next values; never cleared by service
  wire [3:0] mset = {PER_MATCH_A_IN, PER_MATCH_P_IN, STD_MATCH_A_IN, STD_MATCH_P_IN};
  wire [3:0] mwr = {wr_g1, wr_g1, wr_g0, wr_g0};
  wire [3:0] mwd = {wd[`VIC_GRP_AF], wd[`VIC_GRP_PF], wd[`VIC_GRP_AF], wd[`VIC_GRP_PF]};
  wire [3:0] mflag_d;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_mem
      assign mflag_d[gi] = upd(mflag_q[gi], mwr[gi], mwd[gi], mset[gi], 1'b0);
    end
  endgenerate
  // Rising member flags feed the group flags
  wire [3:0] mrise = mflag_d & ~mflag_q;

  // ----------------------------------------
  // Arbitration and service
  // ----------------------------------------
  // Enables in direct-flag order: pin, g0, g1, t0, t1, conv
  wire [5:0] den = {c1_en_q, c0_en_q};
  wire [5:0] pend = dflag_q & den;
  // Decide only at an instruction boundary
  wire want = CORE_BOUNDARY_IN & gie_q & (|pend);
  wire take = want & ~STACK_FULL_IN;
  // Lowest bit wins, so bit order is priority order
  wire [5:0] grant = take ? prio(pend) : 6'h00;
  // Group flags share the auto clear of direct ones
  wire [5:0] dset = {CONV_DONE_IN, TICK1_IN, TICK0_IN,
                     |mrise[3:2], |mrise[1:0], ext_set};
  wire [5:0] dwr = {wr_c1, wr_c1, wr_c1, wr_c0, wr_c0, wr_c0};
  wire [5:0] dwd = {wd[`VIC_C1_CVF], wd[`VIC_C1_T1F], wd[`VIC_C1_T0F],
                    wd[`VIC_C0_G1F], wd[`VIC_C0_G0F], wd[`VIC_C0_EXTF]};
  wire [5:0] dflag_d;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_dir
      // Latches even while globally disabled
      assign dflag_d[gi] = upd(dflag_q[gi], dwr[gi], dwd[gi], dset[gi], grant[gi]);
    end
  endgenerate
  // Any flag turning on wakes the core
  wire any_rise = (|(dflag_d & ~dflag_q)) | (|mrise);
  // Events: taken, held off by stack, wake
  wire [2:0] evt_set = {any_rise, want & STACK_FULL_IN, take};

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  // Two stages before any logic reads the pin
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_old_q <= 1'b0;
    end else begin
      pin_s1_q <= EXT_PIN_IN;
      pin_s2_q <= pin_s1_q;
      pin_old_q <= pin_s2_q;
    end
  end

  // ----------------------------------------
  // Bus slave: ack one cycle after request
  // ----------------------------------------
  // Read data is captured on the request edge
  // Trade-off: one wait state keeps read data registered
  reg [31:0] rmux; // Read multiplexer
  always @* begin
    rmux = 32'h00000000;
    if (WB_ADR_IN == `VIC_ADR_EDGE) begin
      rmux[3:0] = {edge_rsv_q, edge_q};
    end else if (WB_ADR_IN == `VIC_ADR_CTRL0) begin
      rmux[6:0] = {dflag_q[2:0], c0_en_q, gie_q};
    end else if (WB_ADR_IN == `VIC_ADR_CTRL1) begin
      rmux[7:0] = {dflag_q[5], c1_rsv_q[1], dflag_q[4:3], c1_en_q[2], c1_rsv_q[0], c1_en_q[1:0]};
    end else if (WB_ADR_IN == `VIC_ADR_GRP0) begin
      rmux[5:0] = {mflag_q[1:0], 2'h0, men_q[1:0]};
    end else if (WB_ADR_IN == `VIC_ADR_GRP1) begin
      rmux[5:0] = {mflag_q[3:2], 2'h0, men_q[3:2]};
    end else if (WB_ADR_IN == `VIC_ADR_STAT) begin
      rmux[12:0] = {last_vec_q, 6'h00, |pend, STACK_FULL_IN};
    end else if (WB_ADR_IN == `VIC_ADR_EVT) begin
      rmux[2:0] = evt_q;
    end else if (WB_ADR_IN == `VIC_ADR_MASK) begin
      rmux[2:0] = mask_q;
    end else begin
      rmux = 32'h00000000; // Unmapped reads zero
    end
  end

  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        rdat_q <= rmux;
      end
    end
  end

  // ----------------------------------------
  // Control and enable registers
  // ----------------------------------------
  // Service clear of global enable wins over a write
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      edge_q <= 2'h0;
      edge_rsv_q <= 2'h0;
      gie_q <= 1'b0;
      c0_en_q <= 3'h0;
      c1_en_q <= 3'h0;
      c1_rsv_q <= 2'h0;
      men_q <= 4'h0;
      mask_q <= 3'h0;
    end else begin
      // Reserved edge bits are kept for read back
      if (wr_edge) begin
        edge_q <= wd[1:0];
        edge_rsv_q <= wd[3:2];
      end
      if (take) begin
        gie_q <= 1'b0;
      end else if (wr_c0) begin
        gie_q <= wd[`VIC_C0_GIE];
      end
      if (wr_c0) begin
        c0_en_q <= {wd[`VIC_C0_G1E], wd[`VIC_C0_G0E], wd[`VIC_C0_EXTE]};
      end
      if (wr_c1) begin
        c1_en_q <= {wd[`VIC_C1_CVE], wd[`VIC_C1_T1E], wd[`VIC_C1_T0E]};
        c1_rsv_q <= {wd[6], wd[2]};
      end
      if (wr_g0) begin
        men_q[1:0] <= {wd[`VIC_GRP_AE], wd[`VIC_GRP_PE]};
      end
      if (wr_g1) begin
        men_q[3:2] <= {wd[`VIC_GRP_AE], wd[`VIC_GRP_PE]};
      end
      if (wr_mask) begin
        mask_q <= wd[2:0];
      end
    end
  end

  // ----------------------------------------
  // Flags and event status
  // ----------------------------------------
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      dflag_q <= 6'h00;
      mflag_q <= 4'h0;
      evt_q <= `VIC_RST_EVT;
    end else begin
      // Flags take their next values from the update function
      dflag_q <= dflag_d;
      mflag_q <= mflag_d;
      // Write one clears; a new event in the same cycle stays
      evt_q <= evt_set | (evt_q & ~(wr_evt ? wd[2:0] : 3'h0));
    end
  end

  // ----------------------------------------
  // Core side strobes
  // ----------------------------------------
  // Strobes are one cycle; the core does push then jump
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      call_q <= 1'b0;
      pop_q <= 1'b0;
      wake_q <= 1'b0;
      push_q <= {PC_W{1'b0}};
      vec_q <= {PC_W{1'b0}};
      last_vec_q <= 5'h00;
    end else begin
      call_q <= take;
      pop_q <= CORE_RETURN_IN;
      wake_q <= any_rise;
      if (take) begin
        push_q <= CORE_NEXT_PC_IN;
        // Vector is zero extended to the program counter width
        vec_q <= {{(PC_W-5){1'b0}}, vec_of(grant)};
        last_vec_q <= vec_of(grant);
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign WB_ACK_OUT = ack_q;
  assign WB_DAT_OUT = rdat_q;
  assign CALL_OUT = call_q;
  assign PUSH_PC_OUT = push_q;
  assign VECTOR_OUT = vec_q;
  assign POP_OUT = pop_q;
  assign WAKE_OUT = wake_q;
  // Level interrupt: any unmasked event bit
  assign IRQ_OUT = |(evt_q & mask_q);

endmodule // vic_top

// file: testbench/vic_top_monitor.sv
// Checker on the interrupt controller ports
`timescale 1ns/100ps
module vic_top_monitor #(
  parameter PC_W = 13
) (
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  input wire WB_CYC_IN,
  input wire WB_STB_IN,
  input wire WB_ACK_OUT,
  input wire CORE_BOUNDARY_IN,
  input wire [PC_W-1:0] CORE_NEXT_PC_IN,
  input wire CORE_RETURN_IN,
  input wire STACK_FULL_IN,
  input wire CALL_OUT,
  input wire [PC_W-1:0] PUSH_PC_OUT,
  input wire [PC_W-1:0] VECTOR_OUT,
  input wire POP_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_req;
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  endsequence
  sequence s_ack;
    WB_ACK_OUT ##1 !WB_ACK_OUT;
  endsequence
  sequence s_blocked;
    CORE_BOUNDARY_IN && STACK_FULL_IN;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_bus_ack_pulse: assert property (s_req |=> s_ack)
    else $error("bus ack not a single pulse");
  a_full_holds_off: assert property (s_blocked |=> !CALL_OUT)
    else $error("call taken with full stack");
  a_call_at_boundary: assert property (CALL_OUT |-> $past(CORE_BOUNDARY_IN) && !$past(STACK_FULL_IN))
    else $error("call without free boundary");
  a_push_next_pc: assert property (CALL_OUT |-> PUSH_PC_OUT == $past(CORE_NEXT_PC_IN))
    else $error("pushed pc wrong");
  a_vector_legal: assert property (CALL_OUT |-> VECTOR_OUT inside {13'h04, 13'h08, 13'h0C, 13'h10, 13'h14, 13'h1C})
    else $error("vector not in table");
  a_no_nesting: assert property (CALL_OUT |=> !CALL_OUT)
    else $error("back to back calls");
  a_vector_holds: assert property (!CALL_OUT |-> $stable(VECTOR_OUT) && $stable(PUSH_PC_OUT))
    else $error("vector moved without call");
  a_pop_follows: assert property (1'b1 |-> POP_OUT == $past(CORE_RETURN_IN))
    else $error("pop not one cycle after return");
endmodule // vic_top_monitor
bind vic_top vic_top_monitor #(.PC_W(PC_W)) u_vic_top_monitor (.REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN),
  .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_ACK_OUT(WB_ACK_OUT), .CORE_BOUNDARY_IN(CORE_BOUNDARY_IN),
  .CORE_NEXT_PC_IN(CORE_NEXT_PC_IN), .CORE_RETURN_IN(CORE_RETURN_IN), .STACK_FULL_IN(STACK_FULL_IN),
  .CALL_OUT(CALL_OUT), .PUSH_PC_OUT(PUSH_PC_OUT), .VECTOR_OUT(VECTOR_OUT), .POP_OUT(POP_OUT));

// file: testbench/vic_core_model.sv
// Behavioural core: boundary pulses, fetch address and stack depth
`timescale 1ns/100ps
module vic_core_model #(
  parameter PC_W = 13,
  parameter DEPTH = 2 // Small stack so the full case is cheap to reach
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire run_in,
  input wire call_in,
  input wire pop_in,
  input wire [PC_W-1:0] vec_in,
  output wire bnd_out,
  output wire [PC_W-1:0] pc_out,
  output wire full_out
);
  logic [1:0] phase_q; // Boundary every fourth cycle
  logic [3:0] depth_q; // Entries on the stack
  logic bnd_q; // Boundary strobe
  logic [PC_W-1:0] pc_q; // Next fetch address
  assign bnd_out = bnd_q;
  assign pc_out = pc_q;
  assign full_out = (depth_q == DEPTH);
  // Core stepping; a call replaces the fetch by the vector
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_q <= 2'h0;
      depth_q <= 4'h0;
      bnd_q <= 1'b0;
      pc_q <= '0;
    end else begin
      phase_q <= phase_q + 2'h1;
      bnd_q <= run_in && (phase_q == 2'h3);
      if (call_in) begin
        pc_q <= vec_in;
      end else if (bnd_q) begin
        pc_q <= pc_q + 1'b1;
      end
      depth_q <= depth_q + {3'h0, call_in} - {3'h0, pop_in};
    end
  end
endmodule // vic_core_model

// file: testbench/vic_top_bench.sv
// Register and core-link tests of the interrupt controller
`timescale 1ns/100ps
`include "vic_map.vh"
module vic_top_bench;
  logic clk, rst_n, cyc, stb, we, pin, smp, sma, pmp, pma, t0, t1, cv, ret, run;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dat_o, r;
  logic ack, bnd, full, call, pop, wake, irq;
  logic [12:0] npc, ppc, vec;
  int n_mismatch, cmp_count, n_call, i, k;
  logic [12:0] vtab [6] = '{13'h04, 13'h08, 13'h0C, 13'h10, 13'h14, 13'h1C}; // Highest priority first
  vic_top u_vic_top (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat), .WB_DAT_OUT(dat_o), .WB_ACK_OUT(ack), .EXT_PIN_IN(pin),
    .STD_MATCH_P_IN(smp), .STD_MATCH_A_IN(sma), .PER_MATCH_P_IN(pmp), .PER_MATCH_A_IN(pma), .TICK0_IN(t0),
    .TICK1_IN(t1), .CONV_DONE_IN(cv), .CORE_BOUNDARY_IN(bnd), .CORE_NEXT_PC_IN(npc), .CORE_RETURN_IN(ret),
    .STACK_FULL_IN(full), .CALL_OUT(call), .PUSH_PC_OUT(ppc), .VECTOR_OUT(vec), .POP_OUT(pop), .WAKE_OUT(wake),
    .IRQ_OUT(irq));
  vic_core_model u_vic_core_model (.clk_in(clk), .rst_n_in(rst_n), .run_in(run), .call_in(call), .pop_in(pop),
    .vec_in(vec), .bnd_out(bnd), .pc_out(npc), .full_out(full));
  // ----------------------------------------
  // Clock, call counter, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (call === 1'b1) n_call <= n_call + 1;
  initial begin
    #(40 * 20000);
    n_mismatch++;
    tally_and_finish();
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Classic cycle; request held until ack is sampled high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, 4'hF};
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_o;
    {cyc, stb, we} <= 3'h0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, r);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task wait_call(input logic [12:0] v);
    int c;
    c = n_call;
    repeat (40) if (n_call == c) @(posedge clk);
    chk(32'(n_call - c), 32'h1);
    chk(32'(vec), 32'(v));
  endtask
  // Return from the service routine pops one entry
  task do_pop();
    @(posedge clk) ret <= 1'b1;
    @(posedge clk) ret <= 1'b0;
  endtask
  task pulse(input int n);
    repeat (n) @(posedge clk);
  endtask
  task tally_and_finish();
    $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n, cyc, stb, we, pin, smp, sma, pmp, pma, t0, t1, cv, ret, run} = 14'h0;
    {adr, sel, dat} = '0;
    pulse(8);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i++) rdc(8'(4 * i), 32'h0);
    rdc(8'h20, 32'h0);
    wr(`VIC_ADR_GRP1, 32'hFF);
    rdc(`VIC_ADR_GRP1, 32'h33);
    rdc(`VIC_ADR_CTRL0, 32'h40);
    wr(`VIC_ADR_GRP1, 32'h0);
    wr(`VIC_ADR_CTRL0, 32'h0);
    // Every edge code against a rising then a falling pin
    for (i = 0; i < 4; i++) begin
      wr(`VIC_ADR_EDGE, 32'(i));
      @(posedge clk) pin <= 1'b1;
      pulse(6);
      rdc(`VIC_ADR_CTRL0, 32'(i & 1) << 4);
      wr(`VIC_ADR_CTRL0, 32'h0);
      @(posedge clk) pin <= 1'b0;
      pulse(6);
      rdc(`VIC_ADR_CTRL0, 32'(i >> 1) << 4);
      wr(`VIC_ADR_CTRL0, 32'h0);
    end
    // Wake pulse, sticky event, mask and level output
    wr(`VIC_ADR_EVT, 32'h7);
    wr(`VIC_ADR_MASK, 32'h4);
    @(posedge clk) t0 <= 1'b1;
    @(posedge clk) t0 <= 1'b0;
    #1 chk(32'(wake), 32'h1);
    chk(32'(irq), 32'h1);
    rdc(`VIC_ADR_EVT, 32'h4);
    rdc(`VIC_ADR_CTRL1, 32'h10);
    wr(`VIC_ADR_EVT, 32'h4);
    #1 chk(32'(irq), 32'h0);
    wr(`VIC_ADR_CTRL1, 32'h0);
    // Group member with the global enable low, then high
    wr(`VIC_ADR_CTRL0, 32'h08);
    wr(`VIC_ADR_GRP1, 32'h02);
    run <= 1'b1;
    @(posedge clk) pma <= 1'b1;
    @(posedge clk) pma <= 1'b0;
    pulse(20);
    chk(n_call, 32'h0);
    rdc(`VIC_ADR_GRP1, 32'h22);
    rdc(`VIC_ADR_CTRL0, 32'h48);
    wr(`VIC_ADR_CTRL0, 32'h49);
    wait_call(13'h0C);
    rdc(`VIC_ADR_CTRL0, 32'h08);
    rdc(`VIC_ADR_GRP1, 32'h22);
    @(posedge clk) t1 <= 1'b1;
    @(posedge clk) t1 <= 1'b0;
    pulse(2);
    rdc(`VIC_ADR_CTRL1, 32'h20);
    wr(`VIC_ADR_GRP1, 32'h0);
    do_pop();
    // Flag without its own enable takes nothing
    wr(`VIC_ADR_CTRL1, 32'h10);
    wr(`VIC_ADR_CTRL0, 32'h01);
    pulse(20);
    chk(n_call, 32'h1);
    // Fill the stack; the third request waits for a pop
    for (i = 0; i < 3; i++) begin
      wr(`VIC_ADR_CTRL1, 32'h11);
      wr(`VIC_ADR_CTRL0, 32'h01);
      if (i < 2) wait_call(13'h10);
    end
    k = n_call;
    pulse(30);
    chk(n_call, k);
    rdc(`VIC_ADR_STAT, 32'h1003);
    rdc(`VIC_ADR_EVT, 32'h7);
    do_pop();
    wait_call(13'h10);
    do_pop();
    do_pop();
    // All six sources at once, served in priority order
    wr(`VIC_ADR_GRP0, 32'h02);
    wr(`VIC_ADR_GRP1, 32'h02);
    wr(`VIC_ADR_CTRL1, 32'h0B);
    wr(`VIC_ADR_CTRL0, 32'h0E);
    @(posedge clk) {pin, smp, sma, pmp, pma, t0, t1, cv} <= 8'hFF;
    @(posedge clk) {smp, sma, pmp, pma, t0, t1, cv} <= 7'h0;
    pulse(8);
    rdc(`VIC_ADR_GRP0, 32'h32);
    rdc(`VIC_ADR_GRP1, 32'h32);
    for (i = 0; i < 6; i++) begin
      bus(1'b0, `VIC_ADR_CTRL0, 32'h0, r);
      wr(`VIC_ADR_CTRL0, r | 32'h1);
      wait_call(vtab[i]);
      do_pop();
    end
    tally_and_finish();
  end
endmodule // vic_top_bench
